// ### core/cff_pkg.sv
package cff_pkg;

    localparam int unsigned CFF_DEPTH_SMALL = 65536;
    localparam int unsigned CFF_DEPTH_LARGE = 131072;
    localparam int unsigned CFF_WIDTH = 9;

    localparam logic [31:0] CFF_ADDR_OFS_FULL = 32'h0000_0000;
    localparam logic [31:0] CFF_ADDR_OFS_EMPTY = 32'h0000_0004;
    localparam logic [31:0] CFF_ADDR_STATUS = 32'h0000_0008;
    localparam logic [31:0] CFF_OFS_RST = 32'h0000_007F;

    localparam int unsigned CFF_ST_FLAG_LSB = 24;
    localparam int unsigned CFF_ST_MODE_BIT = 31;
    localparam logic [1:0] CFF_CAP_DONE = 2'h3;

    typedef struct packed {
        logic half_full_flag_n;
        logic almost_full_flag_n;
        logic almost_empty_flag_n;
        logic full_flag_n;
        logic input_ready_flag_n;
        logic empty_flag_n;
        logic output_ready_flag_n;
    } cff_flags_s;

    localparam cff_flags_s CFF_FLAGS_RST = '{
        half_full_flag_n: 1'b1, almost_full_flag_n: 1'b1, almost_empty_flag_n: 1'b0,
        full_flag_n: 1'b1, input_ready_flag_n: 1'b1, empty_flag_n: 1'b0,
        output_ready_flag_n: 1'b1};

endpackage

// ### core/cff_mem.sv
`timescale 1ns/100ps
module cff_mem #(
    parameter int unsigned W = 9,
    parameter int unsigned DEPTH = 65536,
    parameter int unsigned AW = $clog2(DEPTH)
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data_q
);
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge hclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // old word stays on the output until the next fetch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_data_q <= '0;
        end else if (rd_en) begin
            rd_data_q <= mem[rd_addr];
        end
    end
endmodule

// ### core/cff_fifo_flags.sv
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
// Notes on behaviour
// - standard depth 65,536 or 131,072 words
// - fall-through depth one word larger
// - almost-full releases one cycle after read
// - almost-full updates only on clock edges
// - almost-empty releases one cycle after write
// - output-ready low when word is presented
// - input-ready low when space is free
// - only first word shows ripple delay
// - output-ready rises only on last read
module cff_fifo_flags
    import cff_pkg::*;
#(
    parameter int unsigned DEPTH = CFF_DEPTH_SMALL,
    parameter int unsigned W = CFF_WIDTH
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic fall_through_mode,
    input wire logic wr_en_n,
    input wire logic [W-1:0] wr_data,
    input wire logic rd_en_n,
    output logic [W-1:0] rd_data,
    output cff_flags_s flags
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned CW = AW + 2;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
    localparam logic [CW-1:0] HALF_C = CW'(DEPTH / 2);

    ////////////////////////////////////////////////////////////////////////////
    // mode strap, sampled after reset release
    logic mode_s1_q, mode_s2_q, mode_s3_q;
    logic [1:0] cap_cnt_q;
    logic mode_lock_q, ft_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_s1_q <= 1'b0;
            mode_s2_q <= 1'b0;
            mode_s3_q <= 1'b0;
        end else begin
            mode_s1_q <= fall_through_mode;
            mode_s2_q <= mode_s1_q;
            mode_s3_q <= mode_s2_q;
        end
    end

    // strap is frozen once taken: mode cannot change under live data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_cnt_q <= '0;
            mode_lock_q <= 1'b0;
            ft_q <= 1'b0;
        end else if (!mode_lock_q) begin
            if (cap_cnt_q != CFF_CAP_DONE) begin
                cap_cnt_q <= cap_cnt_q + 2'h1;
            end else if (mode_s2_q == mode_s3_q) begin
                mode_lock_q <= 1'b1;
                ft_q <= mode_s3_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // storage and fill level
    logic [AW-1:0] wptr_q, rptr_q;
    logic [CW-1:0] mem_cnt_q, total, depth_eff, ofs_full_q, ofs_empty_q;
    logic out_valid_q;
    logic wr_take, rd_take, fetch;
    cff_flags_s flags_q;

    // overflow guarded by the count itself, not the lagging flag
    assign wr_take = mode_lock_q && !wr_en_n && (mem_cnt_q != DEPTH_C);
    // fall-through: no read while output-ready is high; standard: no read while the count is zero
    assign rd_take = mode_lock_q && !rd_en_n
                     && (ft_q ? !flags_q.output_ready_flag_n : (mem_cnt_q != '0));
    // fall-through prefetches whenever the output stage is free
    assign fetch = ft_q ? ((mem_cnt_q != '0) && (!out_valid_q || rd_take)) : rd_take;
    assign total = mem_cnt_q + CW'(ft_q & out_valid_q);
    assign depth_eff = DEPTH_C + CW'(ft_q);

    cff_mem #(.W(W), .DEPTH(DEPTH), .AW(AW)) u_mem (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(wr_take),
        .wr_addr(wptr_q),
        .wr_data(wr_data),
        .rd_en(fetch),
        .rd_addr(rptr_q),
        .rd_data_q(rd_data)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wptr_q <= '0;
            rptr_q <= '0;
            mem_cnt_q <= '0;
        end else begin
            if (wr_take) begin
                wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + AW'(1);
            end
            if (fetch) begin
                rptr_q <= (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + AW'(1);
            end
            mem_cnt_q <= mem_cnt_q + CW'(wr_take) - CW'(fetch);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_valid_q <= 1'b0;
        end else begin
            out_valid_q <= ft_q && (fetch || (out_valid_q && !rd_take));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flags: registered from the settled level, one edge after the cause; output-ready moves with the output stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_q <= CFF_FLAGS_RST;
        end else begin
            flags_q.output_ready_flag_n <= !(ft_q && (fetch || (out_valid_q && !rd_take)));
            flags_q.empty_flag_n <= (total != '0);
            flags_q.full_flag_n <= (total != depth_eff);
            flags_q.input_ready_flag_n <= (total == depth_eff);
            flags_q.almost_full_flag_n <= (total < depth_eff - ofs_full_q);
            flags_q.almost_empty_flag_n <= (total > ofs_empty_q + CW'(ft_q));
            flags_q.half_full_flag_n <= (total <= HALF_C + CW'(ft_q));
        end
    end
    assign flags = flags_q;

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states
    logic ap_wr_q, hreadyout_q, hresp_q;
    logic [31:0] ap_addr_q, hrdata_q, status;
    logic ap_take;

    assign ap_take = hsel && hready && htrans[1];
    assign status = ({{(32 - CW){1'b0}}, total})
                    | (32'(flags_q) << CFF_ST_FLAG_LSB)
                    | (32'(ft_q) << CFF_ST_MODE_BIT);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_q <= 1'b0;
            ap_addr_q <= '0;
            hrdata_q <= '0;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            ap_wr_q <= ap_take && hwrite;
            ap_addr_q <= haddr;
            if (ap_take && !hwrite) begin
                unique case (haddr)
                    CFF_ADDR_OFS_FULL: hrdata_q <= 32'(ofs_full_q);
                    CFF_ADDR_OFS_EMPTY: hrdata_q <= 32'(ofs_empty_q);
                    CFF_ADDR_STATUS: hrdata_q <= status;
                    default: hrdata_q <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ofs_full_q <= CFF_OFS_RST[CW-1:0];
            ofs_empty_q <= CFF_OFS_RST[CW-1:0];
        end else if (ap_wr_q) begin
            if (ap_addr_q == CFF_ADDR_OFS_FULL) begin
                ofs_full_q <= hwdata[CW-1:0];
            end
            if (ap_addr_q == CFF_ADDR_OFS_EMPTY) begin
                ofs_empty_q <= hwdata[CW-1:0];
            end
        end
    end

    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign hrdata = hrdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    full_std_a: assert property (!ft_q && total == DEPTH_C |=> !flags_q.full_flag_n)
        else $error("full flag missing at standard depth");
    full_ft_a: assert property (ft_q && total == DEPTH_C + 1'b1 |=> flags_q.input_ready_flag_n)
        else $error("input ready not raised at fall-through depth");
    paf_release_a: assert property (rd_take && !wr_take && !ap_wr_q
        && total == depth_eff - ofs_full_q |=> ##1 flags_q.almost_full_flag_n)
        else $error("almost-full late to release");
    paf_stable_a: assert property (($stable(total) && !ap_wr_q) [*2]
        |=> $stable(flags_q.almost_full_flag_n))
        else $error("almost-full moved without cause");
    pae_release_a: assert property (wr_take && !rd_take && !ap_wr_q
        && total == ofs_empty_q + CW'(ft_q) |=> ##1 flags_q.almost_empty_flag_n)
        else $error("almost-empty late to release");
    or_present_a: assert property (ft_q && mem_cnt_q != '0 && !out_valid_q
        |=> !flags_q.output_ready_flag_n && out_valid_q)
        else $error("output ready not low with word presented");
    ir_space_a: assert property (ft_q && rd_take && !wr_take && total == depth_eff
        |=> ##1 !flags_q.input_ready_flag_n)
        else $error("input ready not low after space freed");
    first_word_a: assert property (ft_q && total == '0 && wr_take
        |-> ##2 !flags_q.output_ready_flag_n)
        else $error("first word latency wrong");
    or_rise_a: assert property ($rose(flags_q.output_ready_flag_n) && ft_q
        |-> $past(rd_take))
        else $error("output ready rose without read");

    fill_full_c: cover property (!flags_q.full_flag_n ##1 rd_take);
    ft_first_c: cover property (ft_q && total == '0 ##1 wr_take ##2 rd_take);
    drain_c: cover property (rd_take ##1 !flags_q.empty_flag_n ##1 flags_q.empty_flag_n == 1'b0);
endmodule

// ### dv/cff_reader_model.sv
`timescale 1ns/100ps
module cff_reader_model
    import cff_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic go,
    input wire logic fall_through_mode,
    input wire logic [2*CFF_WIDTH-1:0] rd_data,
    input wire cff_flags_s flags,
    input wire cff_flags_s flags_w,
    output logic rd_en_n,
    output logic [2*CFF_WIDTH-1:0] got [32],
    output int n_got
);
    logic pend_q, empty_c, ready_c;
    ////////////////////////////////////////////////////////////////
    // composite flags: a device lagging by one cycle holds the group back
    assign empty_c = flags.empty_flag_n & flags_w.empty_flag_n;
    assign ready_c = flags.output_ready_flag_n | flags_w.output_ready_flag_n;
    // standard mode reads every other cycle: empty lags one edge
    // one strobe fans out to both devices, outputs never wired together
    assign rd_en_n = !(go && !pend_q && (fall_through_mode ?
        !ready_c : empty_c));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q <= 1'h0;
            n_got <= 0;
        end else begin
            pend_q <= !rd_en_n && !fall_through_mode;
            if (pend_q || (!rd_en_n && fall_through_mode)) begin
                got[n_got[4:0]] <= rd_data;
                n_got <= n_got + 1;
            end
        end
    end
endmodule

// ### dv/cascaded_fifo_flag_logic_test.sv
`timescale 1ns/100ps
module cascaded_fifo_flag_logic_test;
    import cff_pkg::*;
    localparam int unsigned D = 16;
    localparam int unsigned OFS_W = $clog2(D) + 2;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, hreadyout, hresp;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, st;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2;
    logic ftm = 1'h0, wr_en_n = 1'h1, rd_en_n, go = 1'h0;
    logic [8:0] wr_data = '0, rd_data;
    logic [8:0] wr_data_w, rd_data_w;
    logic [17:0] got [32];
    cff_flags_s flags, flags_w;
    int n_got, n_mismatch = 0, cmp_count = 0, deff;

    // one free-running clock doubles as transfer clock
    always #5 hclk = ~hclk;

    // second device carries the upper nine bits of the wide word
    assign wr_data_w = ~wr_data;

    cff_fifo_flags #(.DEPTH(D)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .fall_through_mode(ftm), .wr_en_n(wr_en_n), .wr_data(wr_data),
        .rd_en_n(rd_en_n), .rd_data(rd_data), .flags(flags));
    cff_fifo_flags #(.DEPTH(D)) dut_w (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(),
        .fall_through_mode(ftm), .wr_en_n(wr_en_n), .wr_data(wr_data_w),
        .rd_en_n(rd_en_n), .rd_data(rd_data_w), .flags(flags_w));
    cff_reader_model reader (.hclk(hclk), .hresetn(hresetn), .go(go),
        .fall_through_mode(ftm), .rd_data({rd_data_w, rd_data}), .flags(flags),
        .flags_w(flags_w), .rd_en_n(rd_en_n), .got(got), .n_got(n_got));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t %s: got %h want %h", $time, m, g, e);
        end
    endtask

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        st = hrdata;
        chk(32'(hresp), '0, "response");
    endtask

    // back-to-back writes, one word per edge
    task automatic fwr(input int k, input int b);
        wr_en_n <= 1'h0;
        for (int i = 0; i < k; i++) begin
            wr_data <= 9'(b + i * 37);
            @(posedge hclk);
        end
        wr_en_n <= 1'h1;
    endtask

    task automatic report_and_stop;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_mismatch++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        for (int md = 0; md < 2; md++) begin
            hresetn <= 1'h0;
            ftm <= md[0];
            deff = D + md;
            repeat (16) @(posedge hclk);
            hresetn <= 1'h1;
            repeat (8) @(posedge hclk);
            ahb(1'h0, CFF_ADDR_OFS_FULL, '0);
            // offset register keeps only the level's width
            chk(st, 32'(CFF_OFS_RST[OFS_W-1:0]), "full offset reset");
            ahb(1'h1, CFF_ADDR_OFS_FULL, '0);
            ahb(1'h1, CFF_ADDR_OFS_EMPTY, 32'h0000_0002);
            ahb(1'h1, 32'h0000_000C, 32'h0000_0055);
            ahb(1'h0, 32'h0000_000C, '0);
            chk(st, '0, "unmapped");
            ahb(1'h0, CFF_ADDR_OFS_EMPTY, '0);
            chk(st, 32'h0000_0002, "empty offset");
            // two extra words must be dropped at the full depth
            fwr(deff + 2, 0);
            repeat (2) @(posedge hclk);
            ahb(1'h0, CFF_ADDR_STATUS, '0);
            chk({st[31], st[5:0]}, {md[0], 6'(deff)}, "mode and level");
            chk(md[0] ? flags.input_ready_flag_n : !flags.full_flag_n, 1, "full");
            chk(md[0] ? (flags.input_ready_flag_n | flags_w.input_ready_flag_n)
                : !(flags.full_flag_n & flags_w.full_flag_n), 1, "composite full");
            chk(flags.half_full_flag_n, 0, "half");
            go <= 1'h1;
            @(posedge hclk);
            go <= 1'h0;
            @(posedge hclk);
            chk(flags.almost_full_flag_n, 0, "af early");
            @(posedge hclk);
            chk(flags.almost_full_flag_n, 1, "af late");
            go <= 1'h1;
            for (int i = 0; i < 200 && n_got < deff; i++) @(posedge hclk);
            go <= 1'h0;
            repeat (4) @(posedge hclk);
            chk(n_got, deff, "read count");
            for (int i = 0; i < deff; i++) chk(got[i], {~9'(i * 37), 9'(i * 37)}, "data");
            chk(md[0] ? flags.output_ready_flag_n : !flags.empty_flag_n, 1, "empty");
            fwr(3 + md, 100);
            @(posedge hclk);
            chk(flags.almost_empty_flag_n, 0, "ae early");
            @(posedge hclk);
            chk(flags.almost_empty_flag_n, 1, "ae late");
            chk(md[0] ? !flags.output_ready_flag_n : flags.empty_flag_n, 1, "ready");
        end
        report_and_stop();
    end
endmodule
